// >>> input_signal_router_pkg.sv
`default_nettype none

package input_signal_router_pkg;

  // ***************************************************
  // register map
  // ***************************************************
  localparam int          REG_COUNT       = 8;
  localparam int          IDX_MAKER       = 0;
  localparam int          IDX_AUTO_ON     = 1;
  localparam int          IDX_SEL1        = 2;
  localparam int          IDX_SEL2        = 3;
  localparam int          IDX_SEL3        = 4;
  localparam int          IDX_SEL4        = 5;
  localparam int          IDX_SEL5        = 6;
  localparam int          IDX_STROKE      = 7;
  localparam logic [7:0]  ADDR_STATUS     = 8'h20;

  // ***************************************************
  // values after reset
  // ***************************************************
  localparam logic [15:0] RST_MAKER       = 16'h0000;
  localparam logic [15:0] RST_AUTO_ON     = 16'h0000;
  localparam logic [15:0] RST_SEL1        = 16'h0002;
  localparam logic [15:0] RST_SEL2        = 16'h0111;
  localparam logic [15:0] RST_SEL3        = 16'h0882;
  localparam logic [15:0] RST_SEL4        = 16'h0995;
  localparam logic [15:0] RST_SEL5        = 16'h0000;
  localparam logic [15:0] RST_STROKE      = 16'h0403;
  localparam logic [15:0] RST_VALUES [REG_COUNT] = '{RST_MAKER, RST_AUTO_ON, RST_SEL1,
    RST_SEL2, RST_SEL3, RST_SEL4, RST_SEL5, RST_STROKE};

  // ***************************************************
  // digit fields
  // ***************************************************
  localparam int          POS_LSB         = 0;
  localparam int          SPD_LSB         = 4;
  localparam int          AUTO_SON_LSB    = 0;
  localparam int          AUTO_FWD_LSB    = 4;
  localparam int          AUTO_REV_LSB    = 8;
  localparam int          CR_MODE_LSB     = 0;
  localparam int          MODE_PIN_LSB    = 4;
  localparam int          FWD_PIN_LSB     = 0;
  localparam int          REV_PIN_LSB     = 8;
  localparam logic [3:0]  AUTO_FORCED     = 4'h1;
  localparam logic [3:0]  CR_MODE_EDGE    = 4'h0;

  // ***************************************************
  // signal codes and pin codes
  // ***************************************************
  localparam logic [3:0]  CODE_SERVO_ON   = 4'h1;
  localparam logic [3:0]  CODE_RESET      = 4'h2;
  localparam logic [3:0]  CODE_PROP       = 4'h3;
  localparam logic [3:0]  CODE_CLEAR      = 4'h4;
  // pin order: 3, 4, 5, 6, 7
  localparam logic [3:0]  PIN_CODE [5]    = '{4'h1, 4'h2, 4'h5, 4'h3, 4'h4};
  localparam int          ROUTED_PINS     = 4;
  localparam int          PIN_WORD [ROUTED_PINS] = '{IDX_SEL3, IDX_SEL2, IDX_SEL4, IDX_SEL5};

endpackage : input_signal_router_pkg

`default_nettype wire

// >>> input_signal_router.sv
// Local design decisions: the APB slave port and the placing of the registers.
`default_nettype none

// Summary of operation
// R01 - servo-on digit 0 uses its pin, 1 forces it on; word resets to zero
// R02 - forward limit digit 0 uses its pin, 1 forces it on
// R03 - reverse limit digit 0 uses its pin, 1 forces it on
// R04 - word one places mode switch pin and droop clear manner; resets 0002
// R05 - each pin word holds a position code and a speed code, active one used
// R06 - words three to five share word two's codes and digit layout
// R07 - word three drives pin 3, resets 0882
// R08 - word four drives pin 5, resets 0995
// R09 - word five drives pin 6, resets 0000
// R10 - word three ignored when mode switch sits on pin 3
// R11 - word three ignored when either limit sits on pin 3
// R12 - word five ignored when mode switch sits on pin 6
// R13 - word five ignored when reverse limit sits on pin 6
// R14 - software leaves the maker word at zero
// R15 - limit pin selector beats all words; same pin, forward wins
// R16 - a logical input nobody drives or forces stays inactive

module input_signal_router
  import input_signal_router_pkg::*;
#(
  parameter int PIN_COUNT = 5
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [PIN_COUNT-1:0] io_connector_in,
  output logic                      servo_on,
  output logic                      fwd_limit_ok,
  output logic                      rev_limit_ok,
  output logic                      ctrl_mode_switch,
  output logic                      droop_clear,
  output logic                      fault_reset,
  output logic                      proportional_ctrl,
  output logic                      speed_mode
);

  // ***************************************************
  // elaboration check
  // ***************************************************
  if (PIN_COUNT != 5) begin : g_bad_pins
    $error("pin count must be 5");
  end

  // ***************************************************
  // register file over apb
  // ***************************************************
  logic [15:0] cfg_reg [REG_COUNT];
  logic [31:0] prdata_reg;
  logic [7:0]  status_w;
  logic [2:0]  cfg_idx;
  logic        cfg_hit;
  logic        status_hit;
  logic        addr_ok;
  logic        wr_en;
  logic [31:0] rd_next;

  assign cfg_idx    = paddr[4:2];
  assign cfg_hit    = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
  assign status_hit = (paddr == ADDR_STATUS);
  assign addr_ok    = cfg_hit || status_hit;
  assign wr_en      = psel && penable && pwrite && cfg_hit;
  assign rd_next    = cfg_hit ? {16'h0000, cfg_reg[cfg_idx]} :
                      status_hit ? {24'h000000, status_w} : 32'h00000000;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !addr_ok;
  assign prdata     = prdata_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        cfg_reg[i] <= RST_VALUES[i];  // see R01, see R04, see R07, see R08, see R09
      end
    end else if (wr_en) begin
      if (pstrb[0]) begin
        cfg_reg[cfg_idx][7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        cfg_reg[cfg_idx][15:8] <= pwdata[15:8];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata_reg <= rd_next;
    end
  end

  // ***************************************************
  // setting fields
  // ***************************************************
  logic [15:0] auto_w;
  logic [15:0] sel1_w;
  logic [15:0] stroke_w;
  logic        auto_son;
  logic        auto_fwd;
  logic        auto_rev;

  assign auto_w   = cfg_reg[IDX_AUTO_ON];
  assign sel1_w   = cfg_reg[IDX_SEL1];
  assign stroke_w = cfg_reg[IDX_STROKE];
  assign auto_son = auto_w[AUTO_SON_LSB +: 4] == AUTO_FORCED;  // see R01
  assign auto_fwd = auto_w[AUTO_FWD_LSB +: 4] == AUTO_FORCED;  // see R02
  assign auto_rev = auto_w[AUTO_REV_LSB +: 4] == AUTO_FORCED;  // see R03

  // ***************************************************
  // pin claims
  // ***************************************************
  logic [PIN_COUNT-1:0] fwd_oh;
  logic [PIN_COUNT-1:0] rev_raw;
  logic [PIN_COUNT-1:0] rev_oh;
  logic [PIN_COUNT-1:0] mode_oh;
  logic [PIN_COUNT-1:0] limit_claim;
  logic [PIN_COUNT-1:0] mode_eff;
  logic [PIN_COUNT-1:0] pin_valid;
  logic                 same_pin;

  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_claim
    assign fwd_oh[p]  = stroke_w[FWD_PIN_LSB +: 4] == PIN_CODE[p];
    assign rev_raw[p] = stroke_w[REV_PIN_LSB +: 4] == PIN_CODE[p];
    assign mode_oh[p] = sel1_w[MODE_PIN_LSB +: 4] == PIN_CODE[p];  // see R04
  end

  assign same_pin    = |(fwd_oh & rev_raw);
  assign rev_oh      = same_pin ? '0 : rev_raw;                  // see R15
  assign limit_claim = fwd_oh | rev_oh;
  assign mode_eff    = mode_oh & ~limit_claim;                   // see R15
  assign pin_valid   = ~(limit_claim | mode_oh);                 // see R10, see R11, see R12, see R13

  // ***************************************************
  // per-pin signal routing
  // ***************************************************
  logic [ROUTED_PINS-1:0] son_hit;
  logic [ROUTED_PINS-1:0] res_hit;
  logic [ROUTED_PINS-1:0] pc_hit;
  logic [ROUTED_PINS-1:0] cr_hit;
  logic                   speed_mode_reg;

  for (genvar p = 0; p < ROUTED_PINS; p++) begin : g_route
    logic [15:0] word_w;
    logic [3:0]  code_w;
    logic        live_w;
    assign word_w = cfg_reg[PIN_WORD[p]];                       // see R06, see R07, see R08, see R09
    assign code_w = speed_mode_reg ? word_w[SPD_LSB +: 4] : word_w[POS_LSB +: 4];  // see R05
    assign live_w = pin_valid[p] && io_connector_in[p];
    assign son_hit[p] = live_w && (code_w == CODE_SERVO_ON);
    assign res_hit[p] = live_w && (code_w == CODE_RESET);
    assign pc_hit[p]  = live_w && (code_w == CODE_PROP);
    assign cr_hit[p]  = live_w && (code_w == CODE_CLEAR);
  end

  // ***************************************************
  // logical signal registers
  // ***************************************************
  logic servo_on_reg;
  logic fwd_reg;
  logic rev_reg;
  logic mode_reg;
  logic cr_level_reg;
  logic droop_reg;
  logic res_reg;
  logic pc_reg;
  logic cr_level;
  logic servo_on_next;
  logic fwd_next;
  logic rev_next;
  logic mode_next;
  logic droop_next;

  assign servo_on_next = auto_son || (|son_hit);                        // see R01, see R16
  assign fwd_next      = auto_fwd || (|(io_connector_in & fwd_oh));     // see R02, see R16
  assign rev_next      = auto_rev || (|(io_connector_in & rev_oh));     // see R03, see R16
  assign mode_next     = |(io_connector_in & mode_eff);                 // see R04
  assign cr_level      = |cr_hit;
  assign droop_next    = (sel1_w[CR_MODE_LSB +: 4] == CR_MODE_EDGE) ?
                         (cr_level && !cr_level_reg) : cr_level;        // see R04

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      servo_on_reg   <= 1'b0;
      fwd_reg        <= 1'b0;
      rev_reg        <= 1'b0;
      mode_reg       <= 1'b0;
      cr_level_reg   <= 1'b0;
      droop_reg      <= 1'b0;
      res_reg        <= 1'b0;
      pc_reg         <= 1'b0;
      speed_mode_reg <= 1'b0;
    end else begin
      servo_on_reg   <= servo_on_next;
      fwd_reg        <= fwd_next;
      rev_reg        <= rev_next;
      mode_reg       <= mode_next;
      cr_level_reg   <= cr_level;
      droop_reg      <= droop_next;
      res_reg        <= |res_hit;
      pc_reg         <= |pc_hit;
      speed_mode_reg <= mode_next;                                      // see R05
    end
  end

  assign servo_on          = servo_on_reg;
  assign fwd_limit_ok      = fwd_reg;
  assign rev_limit_ok      = rev_reg;
  assign ctrl_mode_switch  = mode_reg;
  assign droop_clear       = droop_reg;
  assign fault_reset       = res_reg;
  assign proportional_ctrl = pc_reg;
  assign speed_mode        = speed_mode_reg;
  assign status_w = {speed_mode_reg, pc_reg, res_reg, droop_reg, mode_reg, rev_reg, fwd_reg,
                     servo_on_reg};

  // ***************************************************
  // assertions
  // ***************************************************
  sequence s_reset_held;
    !rst_b;
  endsequence

  sequence s_defaults;
    (cfg_reg[IDX_AUTO_ON] == RST_AUTO_ON) && (cfg_reg[IDX_SEL1] == RST_SEL1) &&
    (cfg_reg[IDX_SEL3] == RST_SEL3) && (cfg_reg[IDX_SEL4] == RST_SEL4) &&
    (cfg_reg[IDX_SEL5] == RST_SEL5);
  endsequence

  property p_reset_values;
    @(posedge core_clk) s_reset_held |=> s_defaults;
  endproperty
  a_reset_values: assert property (p_reset_values)  // see R07
    else $error("settings not at defaults after reset");

  property p_auto_son;
    @(posedge core_clk) disable iff (!rst_b)
      (auto_w[3:0] == 4'h1) |=> servo_on;
  endproperty
  a_auto_son: assert property (p_auto_son)  // see R01
    else $error("forced servo-on not asserted");

  property p_auto_fwd;
    @(posedge core_clk) disable iff (!rst_b)
      (auto_w[7:4] == 4'h1) [*2] |-> fwd_limit_ok;
  endproperty
  a_auto_fwd: assert property (p_auto_fwd)  // see R02
    else $error("forced forward limit not on");

  property p_auto_rev;
    @(posedge core_clk) disable iff (!rst_b)
      (auto_w[11:8] == 4'h0) && (rev_oh == '0) |=> !rev_limit_ok;
  endproperty
  a_auto_rev: assert property (p_auto_rev)  // see R03
    else $error("reverse limit on with no source");

  property p_mode_pin4;
    @(posedge core_clk) disable iff (!rst_b)
      (sel1_w[7:4] == 4'h2) && !limit_claim[1] && io_connector_in[1] |=> ctrl_mode_switch;
  endproperty
  a_mode_pin4: assert property (p_mode_pin4)  // see R04
    else $error("mode switch pin not followed");

  property p_speed_code;
    @(posedge core_clk) disable iff (!rst_b)
      speed_mode_reg && pin_valid[0] && io_connector_in[0] &&
      (cfg_reg[IDX_SEL3][7:4] == 4'h2) |=> fault_reset;
  endproperty
  a_speed_code: assert property (p_speed_code)  // see R05
    else $error("speed mode code not routed");

  property p_pin3_mode;
    @(posedge core_clk) disable iff (!rst_b)
      (sel1_w[7:4] == 4'h1) |-> !pin_valid[0] && (son_hit[0] == 1'b0);
  endproperty
  a_pin3_mode: assert property (p_pin3_mode)  // see R10
    else $error("word three used while pin 3 holds mode switch");

  property p_pin3_limit;
    @(posedge core_clk) disable iff (!rst_b)
      (stroke_w[3:0] == 4'h1) |-> (res_hit[0] == 1'b0) && (pc_hit[0] == 1'b0);
  endproperty
  a_pin3_limit: assert property (p_pin3_limit)  // see R11
    else $error("word three used while pin 3 holds a limit");

  property p_pin6_mode;
    @(posedge core_clk) disable iff (!rst_b)
      (sel1_w[7:4] == 4'h3) |-> (cr_hit[3] == 1'b0) && (son_hit[3] == 1'b0);
  endproperty
  a_pin6_mode: assert property (p_pin6_mode)  // see R12
    else $error("word five used while pin 6 holds mode switch");

  property p_pin6_rev;
    @(posedge core_clk) disable iff (!rst_b)
      (stroke_w[11:8] == 4'h3) |-> !pin_valid[3];
  endproperty
  a_pin6_rev: assert property (p_pin6_rev)  // see R13
    else $error("word five used while pin 6 holds reverse limit");

  property p_same_pin;
    @(posedge core_clk) disable iff (!rst_b)
      (stroke_w[3:0] == stroke_w[11:8]) && !auto_rev |=> !rev_limit_ok;
  endproperty
  a_same_pin: assert property (p_same_pin)  // see R15
    else $error("reverse limit live on shared pin");

  property p_idle_inputs;
    @(posedge core_clk) disable iff (!rst_b)
      (io_connector_in == '0) && !auto_son [*2] |-> !servo_on && !fault_reset && !proportional_ctrl;
  endproperty
  a_idle_inputs: assert property (p_idle_inputs)  // see R16
    else $error("undriven input not inactive");

endmodule : input_signal_router

`default_nettype wire

// >>> switch_bank_model.sv
`default_nettype none

// ***************************************************
// external switches on the io connector pins
// ***************************************************
module switch_bank_model (
  input  wire logic       core_clk,
  input  wire logic [4:0] switch_req,
  output logic      [4:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // contacts settle just after a clock edge
  always @(posedge core_clk) begin
    pin_level <= switch_req;
  end
endmodule : switch_bank_model

`default_nettype wire

// >>> input_signal_router_test.sv
`default_nettype none

module input_signal_router_test
  import input_signal_router_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ***************************************************
  // signals
  // ***************************************************
  logic        core_clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  switch_req;
  logic [4:0]  pin_level;
  logic        servo_on, fwd_limit_ok, rev_limit_ok, ctrl_mode_switch;
  logic        droop_clear, fault_reset, proportional_ctrl, speed_mode;
  logic [7:0]  outs;
  logic [31:0] rd_data;
  logic        rd_err;
  int          errors;
  int          n_tests;
  int          cycles;

  assign outs = {speed_mode, proportional_ctrl, fault_reset, droop_clear,
                 ctrl_mode_switch, rev_limit_ok, fwd_limit_ok, servo_on};

  input_signal_router #(.PIN_COUNT(5)) uut (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_connector_in(pin_level), .servo_on(servo_on), .fwd_limit_ok(fwd_limit_ok),
    .rev_limit_ok(rev_limit_ok), .ctrl_mode_switch(ctrl_mode_switch),
    .droop_clear(droop_clear), .fault_reset(fault_reset),
    .proportional_ctrl(proportional_ctrl), .speed_mode(speed_mode)
  );

  switch_bank_model partner (
    .core_clk(core_clk), .switch_req(switch_req), .pin_level(pin_level)
  );

  // ***************************************************
  // helpers
  // ***************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [15:0] data);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= {16'h0000, data};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pins(input logic [4:0] p, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    switch_req <= p;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    check(what, {24'h0, outs}, {24'h0, exp});
  endtask : pins

  task automatic stop_test;
    $display("counts: %0d comparisons, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic test_reset;
    for (int i = 0; i < REG_COUNT; i++) begin
      apb(1'b0, 8'(i * 4), 16'h0000);  // every word only read
      check("reset value", rd_data, {16'h0000, RST_VALUES[i]});
    end
    apb(1'b0, 8'h24, 16'h0000);
    check("unmapped error", {31'h0, rd_err}, 32'h1);
    check("unmapped data", rd_data, 32'h0000_0000);
    $display("test reset done");
  endtask : test_reset

  task automatic test_default;
    pins(5'h01, 8'h20, "pin3 word three");
    pins(5'h02, 8'h01, "pin4 word two");
    pins(5'h04, 8'h00, "pin5 word four");
    pins(5'h08, 8'h02, "pin6 forward limit");
    pins(5'h10, 8'h04, "pin7 reverse limit");
    $display("test default done");
  endtask : test_default

  task automatic test_auto;
    apb(1'b1, 8'h04, 16'h0111);
    pins(5'h00, 8'h07, "all forced on");
    apb(1'b0, 8'h20, 16'h0000);
    check("status forced", rd_data, 32'h0000_0007);
    apb(1'b0, 8'h04, 16'h0000);
    check("auto readback", rd_data, 32'h0000_0111);
    apb(1'b1, 8'h04, 16'h0100);
    pins(5'h00, 8'h04, "reverse forced");
    apb(1'b1, 8'h04, 16'h0000);
    pins(5'h00, 8'h00, "nothing forced");
    $display("test auto done");
  endtask : test_auto

  task automatic test_mode;
    apb(1'b1, 8'h10, 16'h0022);
    apb(1'b1, 8'h08, 16'h0052);
    apb(1'b1, 8'h0C, 16'h0031);
    pins(5'h02, 8'h01, "position code");
    pins(5'h06, 8'hC8, "speed code");
    pins(5'h05, 8'hA8, "speed code pin3");
    apb(1'b1, 8'h0C, 16'h0111);
    apb(1'b1, 8'h08, 16'h0012);
    pins(5'h01, 8'h88, "mode on pin3");
    apb(1'b1, 8'h08, 16'h0002);
    apb(1'b1, 8'h10, 16'h0882);
    $display("test mode done");
  endtask : test_mode

  task automatic test_claims;
    apb(1'b1, 8'h14, 16'h0003);
    pins(5'h04, 8'h40, "pin5 word four code");
    apb(1'b1, 8'h14, 16'h0995);
    apb(1'b1, 8'h1C, 16'h0401);
    pins(5'h01, 8'h02, "forward on pin3");
    apb(1'b1, 8'h1C, 16'h0105);
    pins(5'h01, 8'h04, "reverse on pin3");
    apb(1'b1, 8'h1C, 16'h0405);
    apb(1'b1, 8'h18, 16'h0011);
    pins(5'h08, 8'h01, "pin6 word five");
    apb(1'b1, 8'h08, 16'h0032);
    pins(5'h08, 8'h88, "mode on pin6");
    apb(1'b1, 8'h08, 16'h0002);
    apb(1'b1, 8'h1C, 16'h0305);
    pins(5'h08, 8'h04, "reverse on pin6");
    apb(1'b1, 8'h1C, 16'h0303);
    pins(5'h08, 8'h02, "both limits pin6");
    apb(1'b1, 8'h1C, 16'h0403);
    apb(1'b1, 8'h18, 16'h0000);
    $display("test claims done");
  endtask : test_claims

  task automatic test_droop;
    int hi;
    hi = 0;
    apb(1'b1, 8'h10, 16'h0004);
    pins(5'h01, 8'h10, "droop level");
    apb(1'b1, 8'h08, 16'h0000);
    pins(5'h00, 8'h00, "droop idle");
    @(posedge core_clk);
    switch_req <= 5'h01;
    repeat (8) begin
      @(negedge core_clk);
      if (droop_clear === 1'b1) hi++;
    end
    check("droop pulse", 32'(hi), 32'h1);
    $display("test droop done");
  endtask : test_droop

  // ***************************************************
  // clock, reset, run
  // ***************************************************
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end

  initial begin
    errors = 0;
    n_tests = 0;
    cycles = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    switch_req = 5'h00;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    test_reset();
    test_default();
    test_auto();
    test_mode();
    test_claims();
    test_droop();
    stop_test();
  end
endmodule : input_signal_router_test

`default_nettype wire
